// File: logic/lin_consts.svh
// Constants for the LIN control and baud rate generator block.
`ifndef LIN_CONSTS_SVH
`define LIN_CONSTS_SVH

// Register indices; byte address is four times the index.
`define LIN_IDX_STAT0 12'hf41
`define LIN_IDX_CTL0  12'hf42
`define LIN_IDX_CTL1  12'hf43
`define LIN_IDX_PAGE  12'hf44
`define LIN_IDX_COMP  12'hf45
`define LIN_IDX_DIVH  12'hf46
`define LIN_IDX_DIVL  12'hf47

`define LIN_PAGE_MP   3'h0
`define LIN_PAGE_LIN  3'h2
`define LIN_DIV_RST   8'hff
`define LIN_RESP_OK   2'h0
`define LIN_RESP_ERR  2'h2

// Field positions.
`define LIN_C0_PEN    4
`define LIN_C0_SEND_BREAK_BIT   2
`define LIN_MP_MODE1  7
`define LIN_MP_EN     6
`define LIN_MP_MODE0  5
`define LIN_MP_RDAIRQ 1
`define LIN_LC_MST    7
`define LIN_LC_SLV    6
`define LIN_LC_AUTOBAUD_ENABLE   5
`define LIN_LC_AUTOBAUD_IRQ_ENABLE  4
`define LIN_LC_ST     3:2
`define LIN_LC_BRK    1:0
`define LIN_ST_RDA    7
`define LIN_ST_ATB    1

// Timing counts.
`define LIN_BRK_BASE  5'h0d
`define LIN_PRESCALE  4'hf
`define LIN_CNT_END   16'h0001
`endif

// File: logic/lin_pkg.sv
// Types shared by the LIN control and baud rate generator block.
package lin_pkg;

  typedef enum logic [1:0] {
    st_sleep,
    st_wait_break,
    st_autobaud,
    st_active
  } lin_state_t;

  typedef struct packed {
    logic [7:0] ctl0;
    logic [7:0] mp_ctl;
    logic [2:0] ctl1_page_select;
    logic       master_select;
    logic       slave_select;
    logic       autobaud_enable;
    logic       autobaud_irq_enable;
    lin_state_t lin_fsm_state;
    logic [1:0] break_length_sel;
    logic [7:0] comp_addr;
    logic [7:0] divisor_high_byte;
    logic [7:0] divisor_low_byte;
    logic       autobaud_done_flag;
    logic       rx_data_avail_flag;
    logic       addr_match;
    logic       rx_irq;
    logic       master;
    logic       slave;
    logic       ab_active;
    logic       brk_line;
    logic       aw_got;
    logic       w_got;
    logic [15:0] awaddr;
    logic [7:0] wdata;
    logic       wstrb0;
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } ctrl_state_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic [3:0]  pre;
    logic        tick;
    logic        bit_tick;
  } baud_state_t;

  typedef struct packed {
    logic       busy;
    logic [4:0] bits;
    logic       done;
  } brk_state_t;

endpackage

// File: logic/baud_gen.sv
// Baud rate down counter with baud and bit ticks; a bit is sixteen baud ticks outside LIN mode, one in LIN mode.
`include "lin_consts.svh"
module baud_gen (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic [15:0] divisor_in,
  input  wire logic        lin_mode_in,
  output logic             tick_out,
  output logic             bit_tick_out
);
  lin_pkg::baud_state_t b_r;
  lin_pkg::baud_state_t b_nxt;

  // Count down, reload from the divisor and tick at the end.
  always_comb begin
    b_nxt = b_r;
    b_nxt.tick = 1'b0;
    b_nxt.bit_tick = 1'b0;
    if (b_r.cnt <= `LIN_CNT_END) begin
      b_nxt.cnt = divisor_in;
      b_nxt.tick = 1'b1;
      b_nxt.pre = b_r.pre + 4'h1;
      b_nxt.bit_tick = lin_mode_in || (b_r.pre == `LIN_PRESCALE);
    end else begin
      b_nxt.cnt = b_r.cnt - `LIN_CNT_END;
    end
  end

  // State register.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      b_r <= '0;
      b_r.cnt <= {`LIN_DIV_RST, `LIN_DIV_RST};
    end else begin
      b_r <= b_nxt;
    end
  end

  assign tick_out = b_r.tick;
  assign bit_tick_out = b_r.bit_tick;

  property p_reload;
    @(posedge clk_sys_in) disable iff (rst_in)
    (b_r.cnt <= `LIN_CNT_END) |=> tick_out && (b_r.cnt == $past(divisor_in));
  endproperty
  a_reload: assert property (p_reload) else $error("Divisor reload missed.");
endmodule

// File: logic/break_timer.sv
// Times a LIN master break in whole bit ticks.
`include "lin_consts.svh"
module break_timer (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic       start_in,
  input  wire logic       bit_tick_in,
  input  wire logic [1:0] length_sel_in,
  output logic            busy_out,
  output logic            done_out
);
  lin_pkg::brk_state_t k_r;
  lin_pkg::brk_state_t k_nxt;
  logic [4:0] len;
  logic [4:0] bits_inc;

  assign len = `LIN_BRK_BASE + {3'h0, length_sel_in};
  assign bits_inc = k_r.bits + 5'h01;

  // Start on request, then count bit times up to the selected length.
  always_comb begin
    k_nxt = k_r;
    k_nxt.done = 1'b0;
    if (!k_r.busy) begin
      if (start_in && !k_r.done) begin
        k_nxt.busy = 1'b1;
        k_nxt.bits = 5'h00;
      end
    end else if (bit_tick_in) begin
      k_nxt.bits = bits_inc;
      if (bits_inc == len) begin
        k_nxt.busy = 1'b0;
        k_nxt.done = 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      k_r <= '0;
    end else begin
      k_r <= k_nxt;
    end
  end

  assign busy_out = k_r.busy;
  assign done_out = k_r.done;

  property p_brk_len;
    @(posedge clk_sys_in) disable iff (rst_in)
    (k_r.busy && bit_tick_in && (k_r.bits == len - 5'h01)) |=> done_out && !busy_out;
  endproperty
  a_brk_len: assert property (p_brk_len) else $error("Break length wrong.");
endmodule

// File: logic/lin_ctrl.sv
// LIN mode control, address compare and baud divisor with an AXI4-Lite slave.
//
// Local design decision: the AXI4-Lite interface to the registers.
`include "lin_consts.svh"
module lin_ctrl (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        awvalid_in,
  input  wire logic [15:0] awaddr_in,
  input  wire logic        wvalid_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wstrb_in,
  input  wire logic        bready_in,
  input  wire logic        arvalid_in,
  input  wire logic [15:0] araddr_in,
  input  wire logic        rready_in,
  input  wire logic        rx_byte_valid_in,
  input  wire logic [7:0]  rx_byte_in,
  input  wire logic        rx_is_addr_in,
  input  wire logic        rx_data_read_in,
  input  wire logic        rx_break_in,
  input  wire logic        rx_ab_char_in,
  input  wire logic [15:0] rx_ab_period_in,
  output logic             awready_out,
  output logic             wready_out,
  output logic             bvalid_out,
  output logic [1:0]       bresp_out,
  output logic             arready_out,
  output logic             rvalid_out,
  output logic [31:0]      rdata_out,
  output logic [1:0]       rresp_out,
  output logic             rx_irq_out,
  output logic             rx_data_avail_out,
  output logic             baud_tick_out,
  output logic             bit_tick_out,
  output logic             break_active_out,
  output logic             lin_master_out,
  output logic             lin_slave_out,
  output logic             autobaud_active_out,
  output logic [1:0]       lin_state_out
);
  lin_pkg::ctrl_state_t st_r;
  lin_pkg::ctrl_state_t st_nxt;

  logic multiproc_enable;
  logic parity_enable;
  logic send_break_bit;
  logic master_mode;
  logic slave_mode;
  logic lin_mode;
  logic ab_on;
  logic addr_cmp_on;
  logic wr_en;
  logic wr_hit;
  logic [11:0] wr_idx;
  logic wr_lin;
  logic ab_event;
  logic brk_busy;
  logic brk_done;

  // Word index of a byte address.
  function automatic logic [11:0] reg_idx(input logic [15:0] a);
    return a[13:2];
  endfunction

  // True for an aligned address that names a register of this block.
  function automatic logic reg_hit(input logic [15:0] a);
    logic ok;
    ok = 1'b0;
    if ((a[1:0] == 2'h0) && (a[15:14] == 2'h0)) begin
      unique case (reg_idx(a))
        `LIN_IDX_STAT0, `LIN_IDX_CTL0, `LIN_IDX_CTL1, `LIN_IDX_PAGE,
        `LIN_IDX_COMP, `LIN_IDX_DIVH, `LIN_IDX_DIVL: ok = 1'b1;
        default: ok = 1'b0;
      endcase
    end
    return ok;
  endfunction

  // Operating mode decode from the stored control bits.
  assign multiproc_enable = st_r.mp_ctl[`LIN_MP_EN];
  assign parity_enable = st_r.ctl0[`LIN_C0_PEN];
  assign send_break_bit = st_r.ctl0[`LIN_C0_SEND_BREAK_BIT];
  assign master_mode = st_r.master_select && !multiproc_enable && !parity_enable
                       && !st_r.slave_select;
  assign slave_mode = st_r.slave_select && !multiproc_enable && !parity_enable
                      && !st_r.master_select;
  assign lin_mode = master_mode || slave_mode;
  assign ab_on = slave_mode && st_r.autobaud_enable;
  assign addr_cmp_on = multiproc_enable && st_r.mp_ctl[`LIN_MP_MODE1];

  // Write strobe and target, and the autobaud completion event.
  assign wr_en = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign wr_hit = wr_en && st_r.wstrb0 && reg_hit(st_r.awaddr);
  assign wr_idx = reg_idx(st_r.awaddr);
  assign wr_lin = wr_hit && (wr_idx == `LIN_IDX_CTL1)
                  && (st_r.ctl1_page_select == `LIN_PAGE_LIN);
  assign ab_event = (st_r.lin_fsm_state == lin_pkg::st_autobaud) && ab_on
                    && rx_ab_char_in;

  // Baud rate generator on the concatenated divisor.
  baud_gen u_baud (
    .clk_sys_in   (clk_sys_in),
    .rst_in       (rst_in),
    .divisor_in   ({st_r.divisor_high_byte, st_r.divisor_low_byte}),
    .lin_mode_in  (lin_mode),
    .tick_out     (baud_tick_out),
    .bit_tick_out (bit_tick_out)
  );

  // Break timer for a LIN master.
  break_timer u_brk (
    .clk_sys_in    (clk_sys_in),
    .rst_in        (rst_in),
    .start_in      (master_mode && send_break_bit),
    .bit_tick_in   (bit_tick_out),
    .length_sel_in (st_r.break_length_sel),
    .busy_out      (brk_busy),
    .done_out      (brk_done)
  );

  // Next state: bus handshakes, register writes, LIN sequencing, receive filter.
  always_comb begin
    logic [7:0] rd;
    logic       deliver;
    rd = 8'h00;
    deliver = 1'b0;
    st_nxt = st_r;
    st_nxt.rx_irq = 1'b0;

    // Write address and data are taken independently.
    if (awvalid_in && st_r.awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = awaddr_in;
    end
    if (wvalid_in && st_r.wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = wdata_in[7:0];
      st_nxt.wstrb0 = wstrb_in[0];
    end
    if (bready_in && st_r.bvalid) begin
      st_nxt.bvalid = 1'b0;
    end
    if (wr_en) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = reg_hit(st_r.awaddr) ? `LIN_RESP_OK : `LIN_RESP_ERR;
    end

    // Slave sequencing advances on line events only.
    unique case (st_r.lin_fsm_state)
      lin_pkg::st_sleep: begin
      end
      lin_pkg::st_wait_break: begin
        if (slave_mode && rx_break_in) begin
          st_nxt.lin_fsm_state = lin_pkg::st_autobaud;
        end
      end
      lin_pkg::st_autobaud: begin
        if (slave_mode && rx_ab_char_in) begin
          st_nxt.lin_fsm_state = lin_pkg::st_active;
        end
      end
      lin_pkg::st_active: begin
      end
    endcase

    // Register writes; only byte lane zero carries data.
    if (wr_hit) begin
      unique case (wr_idx)
        `LIN_IDX_STAT0: begin
          if (st_r.wdata[`LIN_ST_ATB]) begin
            st_nxt.autobaud_done_flag = 1'b0;
          end
        end
        `LIN_IDX_CTL0: st_nxt.ctl0 = st_r.wdata;
        `LIN_IDX_CTL1: begin
          if (st_r.ctl1_page_select == `LIN_PAGE_MP) begin
            st_nxt.mp_ctl = st_r.wdata;
          end else if (st_r.ctl1_page_select == `LIN_PAGE_LIN) begin
            st_nxt.master_select = st_r.wdata[`LIN_LC_MST];
            st_nxt.slave_select = st_r.wdata[`LIN_LC_SLV];
            st_nxt.autobaud_enable = st_r.wdata[`LIN_LC_AUTOBAUD_ENABLE];
            st_nxt.autobaud_irq_enable = st_r.wdata[`LIN_LC_AUTOBAUD_IRQ_ENABLE];
            st_nxt.lin_fsm_state =
              lin_pkg::lin_state_t'(st_r.wdata[`LIN_LC_ST]);
            st_nxt.break_length_sel = st_r.wdata[`LIN_LC_BRK];
          end
        end
        `LIN_IDX_PAGE: st_nxt.ctl1_page_select = st_r.wdata[2:0];
        `LIN_IDX_COMP: st_nxt.comp_addr = st_r.wdata;
        `LIN_IDX_DIVH: st_nxt.divisor_high_byte = st_r.wdata;
        `LIN_IDX_DIVL: st_nxt.divisor_low_byte = st_r.wdata;
        default: begin
        end
      endcase
    end

    // Autobaud result overrides a divisor write in the same cycle.
    if (ab_event) begin
      st_nxt.divisor_high_byte = rx_ab_period_in[15:8];
      st_nxt.divisor_low_byte = rx_ab_period_in[7:0];
      if (st_r.autobaud_irq_enable) begin
        st_nxt.autobaud_done_flag = 1'b1;
        st_nxt.rx_irq = 1'b1;
      end
    end

    // Completed break releases the send break bit.
    if (brk_done) begin
      st_nxt.ctl0[`LIN_C0_SEND_BREAK_BIT] = 1'b0;
    end

    // Receive filter: address compare gates the flag and the interrupt.
    if (rx_data_read_in) begin
      st_nxt.rx_data_avail_flag = 1'b0;
    end
    if (rx_byte_valid_in) begin
      if (addr_cmp_on) begin
        if (rx_is_addr_in) begin
          st_nxt.addr_match = (rx_byte_in == st_r.comp_addr);
          deliver = (rx_byte_in == st_r.comp_addr)
                    && !st_r.mp_ctl[`LIN_MP_MODE0];
        end else begin
          deliver = st_r.addr_match;
        end
      end else if (multiproc_enable && st_r.mp_ctl[`LIN_MP_MODE0]) begin
        deliver = rx_is_addr_in;
      end else begin
        deliver = 1'b1;
      end
    end
    if (deliver) begin
      st_nxt.rx_data_avail_flag = 1'b1;
      if (!st_r.mp_ctl[`LIN_MP_RDAIRQ]) begin
        st_nxt.rx_irq = 1'b1;
      end
    end

    // Read channel: one read at a time, answered one cycle after address.
    if (rready_in && st_r.rvalid) begin
      st_nxt.rvalid = 1'b0;
    end
    if (arvalid_in && st_r.arready) begin
      unique case (reg_idx(araddr_in))
        `LIN_IDX_STAT0: begin
          rd[`LIN_ST_RDA] = st_r.rx_data_avail_flag;
          rd[`LIN_ST_ATB] = st_r.autobaud_done_flag;
        end
        `LIN_IDX_CTL0: rd = st_r.ctl0;
        `LIN_IDX_CTL1: begin
          if (st_r.ctl1_page_select == `LIN_PAGE_MP) begin
            rd = st_r.mp_ctl;
          end else if (st_r.ctl1_page_select == `LIN_PAGE_LIN) begin
            rd[`LIN_LC_MST] = st_r.master_select;
            rd[`LIN_LC_SLV] = st_r.slave_select;
            rd[`LIN_LC_AUTOBAUD_ENABLE] = st_r.autobaud_enable;
            rd[`LIN_LC_AUTOBAUD_IRQ_ENABLE] = st_r.autobaud_irq_enable;
            rd[`LIN_LC_ST] = st_r.lin_fsm_state;
            rd[`LIN_LC_BRK] = st_r.break_length_sel;
          end
        end
        `LIN_IDX_PAGE: rd[2:0] = st_r.ctl1_page_select;
        `LIN_IDX_COMP: rd = st_r.comp_addr;
        `LIN_IDX_DIVH: rd = st_r.divisor_high_byte;
        `LIN_IDX_DIVL: rd = st_r.divisor_low_byte;
        default: rd = 8'h00;
      endcase
      if (!reg_hit(araddr_in)) begin
        rd = 8'h00;
      end
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd;
      st_nxt.rresp = reg_hit(araddr_in) ? `LIN_RESP_OK : `LIN_RESP_ERR;
    end

    // Ready signals and line outputs, all registered.
    st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid;
    st_nxt.arready = !st_nxt.rvalid;
    st_nxt.master = master_mode;
    st_nxt.slave = slave_mode;
    st_nxt.ab_active = (st_r.lin_fsm_state == lin_pkg::st_autobaud) && ab_on;
    st_nxt.brk_line = lin_mode ? brk_busy : send_break_bit;
  end

  // State register; the divisor bytes reset to all ones.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_r <= '0;
      st_r.divisor_high_byte <= `LIN_DIV_RST;
      st_r.divisor_low_byte <= `LIN_DIV_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register.
  assign awready_out = st_r.awready;
  assign wready_out = st_r.wready;
  assign bvalid_out = st_r.bvalid;
  assign bresp_out = st_r.bresp;
  assign arready_out = st_r.arready;
  assign rvalid_out = st_r.rvalid;
  assign rdata_out = {24'h000000, st_r.rdata};
  assign rresp_out = st_r.rresp;
  assign rx_irq_out = st_r.rx_irq;
  assign rx_data_avail_out = st_r.rx_data_avail_flag;
  assign break_active_out = st_r.brk_line;
  assign lin_master_out = st_r.master;
  assign lin_slave_out = st_r.slave;
  assign autobaud_active_out = st_r.ab_active;
  assign lin_state_out = st_r.lin_fsm_state;

  property p_master_excl;
    @(posedge clk_sys_in) disable iff (rst_in)
    $rose(lin_master_out) |-> $past(st_r.master_select && !st_r.slave_select
                                    && !multiproc_enable && !parity_enable);
  endproperty
  a_master_excl: assert property (p_master_excl) else $error("Bad master mode.");

  property p_slave_excl;
    @(posedge clk_sys_in) disable iff (rst_in)
    lin_slave_out |-> !lin_master_out && $past(!st_r.master_select && !parity_enable);
  endproperty
  a_slave_excl: assert property (p_slave_excl) else $error("Bad slave mode.");

  property p_ab_flag;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ab_event && st_r.autobaud_irq_enable) |=> rx_irq_out && st_r.autobaud_done_flag;
  endproperty
  a_ab_flag: assert property (p_ab_flag) else $error("Autobaud irq missing.");

  property p_ab_load;
    @(posedge clk_sys_in) disable iff (rst_in)
    ab_event |=> ({st_r.divisor_high_byte, st_r.divisor_low_byte}
                  == $past(rx_ab_period_in)) && lin_state_out == 2'h3;
  endproperty
  a_ab_load: assert property (p_ab_load) else $error("Divisor not loaded.");

  property p_wait_adv;
    @(posedge clk_sys_in) disable iff (rst_in)
    (st_r.lin_fsm_state == lin_pkg::st_wait_break && slave_mode && rx_break_in
     && !wr_lin) |=> (lin_state_out == 2'h2);
  endproperty
  a_wait_adv: assert property (p_wait_adv) else $error("No autobaud step.");

  property p_addr_miss;
    @(posedge clk_sys_in) disable iff (rst_in)
    (rx_byte_valid_in && addr_cmp_on && rx_is_addr_in && !ab_event
     && (rx_byte_in != st_r.comp_addr)) |=> !rx_irq_out && !st_r.addr_match;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("Irq on mismatch.");

  property p_brk_clear;
    @(posedge clk_sys_in) disable iff (rst_in)
    brk_done |=> !send_break_bit;
  endproperty
  a_brk_clear: assert property (p_brk_clear) else $error("Send break kept.");
endmodule

// File: bench/lin_node_model.sv
// Far LIN node as seen through the receiver: one-cycle event pulses.
module lin_node_model (
  input  wire logic clk_sys_in,
  output logic       byte_valid_out,
  output logic [7:0] byte_out,
  output logic       is_addr_out,
  output logic       break_out,
  output logic       ab_char_out,
  output logic [15:0] ab_period_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // The line starts idle with no event pending.
  initial begin
    byte_valid_out = 1'b0;
    break_out = 1'b0;
    ab_char_out = 1'b0;
    byte_out = 8'h00;
    is_addr_out = 1'b0;
    ab_period_out = 16'h0000;
  end

  // Kind 0 is a byte, 1 a break, 2 an autobaud character; released data shows the inverse.
  task automatic send(input logic [1:0] kind, input logic [15:0] val, input logic adr);
    @(posedge clk_sys_in);
    byte_valid_out <= (kind == 2'h0);
    break_out <= (kind == 2'h1);
    ab_char_out <= (kind == 2'h2);
    byte_out <= val[7:0];
    is_addr_out <= adr;
    ab_period_out <= val;
    @(posedge clk_sys_in);
    byte_valid_out <= 1'b0;
    break_out <= 1'b0;
    ab_char_out <= 1'b0;
    byte_out <= ~val[7:0];
    is_addr_out <= ~adr;
    ab_period_out <= ~val;
  endtask
endmodule

// File: bench/lin_uart_lin_control_and_baud_gen_test.sv
// Self-checking bench for the LIN control, address compare and baud divisor block.
module lin_uart_lin_control_and_baud_gen_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] a_st0 = 16'h3d04, a_ctl0 = 16'h3d08, a_ctl1 = 16'h3d0c;
  localparam logic [15:0] a_page = 16'h3d10, a_comp = 16'h3d14, a_divh = 16'h3d18;
  localparam logic [15:0] a_divl = 16'h3d1c;
  logic        clk_sys_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        awvalid_in = 1'b0, wvalid_in = 1'b0, bready_in = 1'b0;
  logic        arvalid_in = 1'b0, rready_in = 1'b0, rx_data_read_in = 1'b0;
  logic [15:0] awaddr_in = 16'h0000, araddr_in = 16'h0000;
  logic [31:0] wdata_in = 32'h0;
  logic [3:0]  wstrb_in = 4'h1;
  logic        rx_byte_valid_in, rx_is_addr_in, rx_break_in, rx_ab_char_in;
  logic [7:0]  rx_byte_in, rd;
  logic [15:0] rx_ab_period_in;
  logic        awready_out, wready_out, bvalid_out, arready_out, rvalid_out, rx_irq_out;
  logic [1:0]  bresp_out, rresp_out, lin_state_out, rsp;
  logic [31:0] rdata_out;
  logic        rx_data_avail_out, baud_tick_out, bit_tick_out, break_active_out;
  logic        lin_master_out, lin_slave_out, autobaud_active_out;
  int          fails = 0, total_checks = 0, cyc = 0, n;

  lin_ctrl i_lin_ctrl (.clk_sys_in, .rst_in, .awvalid_in, .awaddr_in, .wvalid_in, .wdata_in,
    .wstrb_in, .bready_in, .arvalid_in, .araddr_in, .rready_in, .rx_byte_valid_in,
    .rx_byte_in, .rx_is_addr_in, .rx_data_read_in, .rx_break_in, .rx_ab_char_in,
    .rx_ab_period_in, .awready_out, .wready_out, .bvalid_out, .bresp_out, .arready_out,
    .rvalid_out, .rdata_out, .rresp_out, .rx_irq_out, .rx_data_avail_out, .baud_tick_out,
    .bit_tick_out, .break_active_out, .lin_master_out, .lin_slave_out,
    .autobaud_active_out, .lin_state_out);
  lin_node_model i_lin_node_model (.clk_sys_in, .byte_valid_out(rx_byte_valid_in),
    .byte_out(rx_byte_in), .is_addr_out(rx_is_addr_in), .break_out(rx_break_in),
    .ab_char_out(rx_ab_char_in), .ab_period_out(rx_ab_period_in));

  // The clock toggles every 20 ns, half of its 40 ns period.
  always #20 clk_sys_in = ~clk_sys_in;

  // Ends a run that hangs.
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      fails++;
      give_verdict();
    end
  end

  // Prints the counts and the verdict, then stops.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Compares a value and counts the outcome.
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  // Compares a single flag.
  task automatic chk1(input string what, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %b seen %b", what, e, g);
    end
  endtask

  // One write: address and data offered together, each released when taken.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    awvalid_in <= 1'b1;
    wvalid_in <= 1'b1;
    awaddr_in <= a;
    wdata_in <= {24'h0, d};
    bready_in <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      if (awready_out) awvalid_in <= 1'b0;
      if (wready_out) wvalid_in <= 1'b0;
    end while (bvalid_out !== 1'b1);
    bready_in <= 1'b0;
  endtask

  // One read; data taken where rvalid is seen.
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d, output logic [1:0] r);
    @(posedge clk_sys_in);
    arvalid_in <= 1'b1;
    araddr_in <= a;
    rready_in <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      if (arready_out) arvalid_in <= 1'b0;
    end while (rvalid_out !== 1'b1);
    d = rdata_out[7:0];
    r = rresp_out;
    rready_in <= 1'b0;
  endtask

  // Reads a register and compares its byte.
  task automatic rchk(input string what, input logic [15:0] a, input logic [7:0] e);
    rd_reg(a, rd, rsp);
    chk(what, {24'h0, e}, {24'h0, rd});
  endtask

  // Lets mode outputs follow a register write.
  task automatic settle();
    repeat (2) @(posedge clk_sys_in);
  endtask

  // Measures the cycles between two bit ticks.
  task automatic tick_gap(output int g);
    @(posedge clk_sys_in);
    while (bit_tick_out !== 1'b1) @(posedge clk_sys_in);
    g = 0;
    do begin
      @(posedge clk_sys_in);
      g++;
    end while (bit_tick_out !== 1'b1);
  endtask

  // Reset values, unmapped access and paging of control 1.
  task automatic t_reset();
    rchk("divisor_high", a_divh, 8'hff);
    rchk("divisor_low", a_divl, 8'hff);
    rchk("comp_addr", a_comp, 8'h00);
    rd_reg(16'h3d40, rd, rsp);
    chk("unmapped_resp", 32'h2, {30'h0, rsp});
    wr(a_page, 8'h02);
    rchk("lin_ctl", a_ctl1, 8'h00);
    wr(a_ctl1, 8'h01);
    rchk("lin_ctl", a_ctl1, 8'h01);
    wr(a_page, 8'h00);
    rchk("mp_ctl", a_ctl1, 8'h00);
    wr(a_page, 8'h02);
    $display("reset test done");
  endtask

  // Master and slave selection and their blocking bits.
  task automatic t_modes();
    wr(a_ctl1, 8'h80);
    settle();
    chk1("master", 1'b1, lin_master_out);
    wr(a_ctl0, 8'h10);
    settle();
    chk1("master", 1'b0, lin_master_out);
    wr(a_ctl0, 8'h00);
    wr(a_ctl1, 8'hc0);
    settle();
    chk1("master", 1'b0, lin_master_out);
    chk1("slave", 1'b0, lin_slave_out);
    wr(a_ctl1, 8'h40);
    settle();
    chk1("slave", 1'b1, lin_slave_out);
    wr(a_page, 8'h00);
    wr(a_ctl1, 8'h40);
    settle();
    chk1("slave", 1'b0, lin_slave_out);
    wr(a_ctl1, 8'h00);
    wr(a_page, 8'h02);
    $display("mode test done");
  endtask

  // Forced state codes, autobaud outside slave mode, master held in wait.
  task automatic t_state();
    for (int s = 0; s < 4; s++) begin
      wr(a_ctl1, 8'h40 | 8'(s << 2));
      settle();
      chk("lin_state", s, {30'h0, lin_state_out});
    end
    wr(a_ctl1, 8'h28);
    settle();
    chk1("autobaud_active", 1'b0, autobaud_active_out);
    wr(a_ctl1, 8'h84);
    i_lin_node_model.send(2'h1, 16'h0, 1'b0);
    settle();
    chk("lin_state", 32'h1, {30'h0, lin_state_out});
    $display("state test done");
  endtask

  // Slave steps through break and autobaud; measured period loads the divisor.
  task automatic t_autobaud();
    wr(a_ctl1, 8'h74);
    i_lin_node_model.send(2'h1, 16'h0, 1'b0);
    #1;
    chk("lin_state", 32'h2, {30'h0, lin_state_out});
    @(posedge clk_sys_in);
    #1;
    chk1("autobaud_active", 1'b1, autobaud_active_out);
    i_lin_node_model.send(2'h2, 16'h0008, 1'b0);
    #1;
    chk1("ab_irq", 1'b1, rx_irq_out);
    chk("lin_state", 32'h3, {30'h0, lin_state_out});
    rchk("status0", a_st0, 8'h02);
    rchk("divisor_low", a_divl, 8'h08);
    rchk("divisor_high", a_divh, 8'h00);
    wr(a_st0, 8'h02);
    rchk("status0", a_st0, 8'h00);
    wr(a_ctl1, 8'h40);
    $display("autobaud test done");
  endtask

  // Bit period in LIN and standard modes from a divisor written in slave mode.
  task automatic t_rate();
    wr(a_divl, 8'h06);
    rchk("divisor_low", a_divl, 8'h06);
    tick_gap(n);
    tick_gap(n);
    chk("lin_bit_gap", 32'd6, n);
    wr(a_ctl1, 8'h00);
    tick_gap(n);
    tick_gap(n);
    chk("std_bit_gap", 32'd96, n);
    $display("rate test done");
  endtask

  // Master break length for every code, then the send-break bit clears itself.
  task automatic t_break();
    for (int s = 0; s < 4; s++) begin
      wr(a_ctl1, 8'h8c | 8'(s));
      wr(a_ctl0, 8'h04);
      n = 0;
      while (break_active_out !== 1'b1) @(posedge clk_sys_in);
      while (break_active_out === 1'b1) begin
        @(posedge clk_sys_in);
        n++;
      end
      chk1("break_len", 1'b1, n > 6 * (12 + s) && n <= 6 * (13 + s) + 3);
      rchk("send_break", a_ctl0, 8'h00);
    end
    wr(a_ctl1, 8'h80);
    $display("break test done");
  endtask

  // Address compare mode gates interrupts and the data flag.
  task automatic t_addr();
    wr(a_ctl1, 8'h00);
    wr(a_comp, 8'h5a);
    wr(a_page, 8'h00);
    wr(a_ctl1, 8'hc0);
    i_lin_node_model.send(2'h0, 16'h0033, 1'b1);
    #1;
    chk1("irq", 1'b0, rx_irq_out);
    chk1("data_avail", 1'b0, rx_data_avail_out);
    i_lin_node_model.send(2'h0, 16'h005a, 1'b1);
    #1;
    chk1("irq", 1'b1, rx_irq_out);
    chk1("data_avail", 1'b1, rx_data_avail_out);
    i_lin_node_model.send(2'h0, 16'h0011, 1'b0);
    #1;
    chk1("irq", 1'b1, rx_irq_out);
    rchk("status0", a_st0, 8'h80);
    @(posedge clk_sys_in);
    rx_data_read_in <= 1'b1;
    @(posedge clk_sys_in);
    rx_data_read_in <= 1'b0;
    #1;
    chk1("data_avail", 1'b0, rx_data_avail_out);
    i_lin_node_model.send(2'h0, 16'h0033, 1'b1);
    i_lin_node_model.send(2'h0, 16'h0022, 1'b0);
    #1;
    chk1("irq", 1'b0, rx_irq_out);
    wr(a_ctl1, 8'he0);
    i_lin_node_model.send(2'h0, 16'h005a, 1'b1);
    #1;
    chk1("irq", 1'b0, rx_irq_out);
    $display("address test done");
  endtask

  // Reset, then every scenario in turn.
  initial begin
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    t_reset();
    t_modes();
    t_state();
    t_autobaud();
    t_rate();
    t_break();
    t_addr();
    give_verdict();
  end
endmodule
